// ---- host_port.sv ----
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 37,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             clr,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("depth must be power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;
  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop  = out_valid && out_ready;
  always_comb begin
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end
  always_ff @(posedge clock) begin
    if (clr) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule // word_fifo

module host_port
  import host_port_pkg::*;
#(
  parameter int DEPTH = host_port_pkg::FIFO_DEPTH
) (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic                      bus_reset_n_in,
  input  wire logic                      hold_mode,
  input  wire logic                      frame_n_in,
  input  wire logic                      irdy_n_in,
  input  wire logic                      trdy_n_in,
  input  wire logic [host_port_pkg::AD_W-1:0]  ad_in,
  output logic      [host_port_pkg::AD_W-1:0]  ad_out,
  output logic                           ad_oe_n,
  input  wire logic [host_port_pkg::CBE_W-1:0] cbe_n_in,
  output logic      [host_port_pkg::CBE_W-1:0] cbe_n_out,
  output logic                           cbe_oe_n,
  input  wire logic                      par_in,
  output logic                           par_out,
  output logic                           par_oe_n,
  input  wire logic                      src_en,
  input  wire host_port_pkg::bus_word_s  src_word,
  output host_port_pkg::captured_s       cap_data,
  output logic                           cap_valid,
  input  wire logic                      cap_ready,
  output logic                           cap_overrun,
  output logic      [LANE_W*CBE_W-1:0]   cap_lane_mask,
  output logic                           par_in_err
);
  import host_port_pkg::*;
  if (DEPTH < 2) begin : g_small_depth
    $error("depth too small");
  end

  // input synchronisers
  logic [WORD_W+3:0] s1_q, s2_q;
  logic              brst1_q, brst2_q, hold1_q, hold2_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q    <= '0;
      s2_q    <= '0;
      brst1_q <= 1'b0;
      brst2_q <= 1'b0;
      hold1_q <= 1'b0;
      hold2_q <= 1'b0;
    end else begin
      s1_q    <= {frame_n_in, irdy_n_in, trdy_n_in, par_in, ad_in, cbe_n_in};
      s2_q    <= s1_q;
      brst1_q <= bus_reset_n_in;
      brst2_q <= brst1_q;
      hold1_q <= hold_mode;
      hold2_q <= hold1_q;
    end
  end
  logic frame_n, irdy_n, trdy_n, par_s;
  bus_word_s bus_w;
  assign {frame_n, irdy_n, trdy_n, par_s, bus_w} = s2_q;

  // bus reset acts unless hold mode protects the state
  logic bus_rst;
  assign bus_rst = !brst2_q && !hold2_q;

  phase_e    ph_q, ph_d;
  logic      par_q, par_d, poe_q, poe_d, prev_frame_q, prev_frame_d;
  logic      ovr_q, ovr_d, perr_q, perr_d, chk_q, chk_d;
  logic      expect_q, expect_d;
  bus_word_s out_q, out_d;
  logic      oe_q, oe_d;
  captured_s cap_in;
  logic      cap_push, fifo_in_ready, last_phase, addr_now;

  // address is on the bus as frame falls
  assign last_phase = frame_n;
  assign addr_now = (ph_q == ST_IDLE) && prev_frame_q && !frame_n;
  assign cap_in.addr_phase = addr_now;
  assign cap_in.word = bus_w;
  assign cap_push = addr_now
                 || (ph_q == ST_DATA && !irdy_n && !trdy_n);

  always_comb begin
    ph_d = ph_q;
    prev_frame_d = frame_n;
    case (ph_q)
      ST_IDLE: if (addr_now) ph_d = ST_DATA;
      ST_DATA: if (last_phase && !irdy_n && !trdy_n) ph_d = ST_IDLE;
      default: ph_d = ST_IDLE;
    endcase
    oe_d  = src_en;
    out_d = src_word;
    par_d = ^{out_q.ad, out_q.cbe_n};
    poe_d = oe_q;
    ovr_d = ovr_q || (cap_push && !fifo_in_ready);
    chk_d = !oe_q && (ph_q != ST_IDLE || addr_now);
    expect_d = ^{bus_w.ad, bus_w.cbe_n};
    perr_d = chk_q && (par_s != expect_q);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ph_q <= ST_IDLE;
      prev_frame_q <= 1'b1;
      oe_q <= 1'b0;
      out_q <= '{ad: AD_ZERO, cbe_n: CBE_IDLE};
      par_q <= 1'b0;
      poe_q <= 1'b0;
      ovr_q <= 1'b0;
      chk_q <= 1'b0;
      expect_q <= 1'b0;
      perr_q <= 1'b0;
    end else if (bus_rst) begin
      ph_q <= ST_IDLE;
      prev_frame_q <= 1'b1;
      oe_q <= 1'b0;
      out_q <= '{ad: AD_ZERO, cbe_n: CBE_IDLE};
      par_q <= 1'b0;
      poe_q <= 1'b0;
      ovr_q <= 1'b0;
      chk_q <= 1'b0;
      expect_q <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      prev_frame_q <= prev_frame_d;
      oe_q <= oe_d;
      out_q <= out_d;
      par_q <= par_d;
      poe_q <= poe_d;
      ovr_q <= ovr_d;
      chk_q <= chk_d;
      expect_q <= expect_d;
      perr_q <= perr_d;
    end
  end

  assign ad_out    = out_q.ad;
  assign cbe_n_out = out_q.cbe_n;
  assign ad_oe_n   = !(oe_q && !bus_rst);
  assign cbe_oe_n  = !(oe_q && !bus_rst);
  assign par_out   = par_q;
  assign par_oe_n  = !(poe_q && !bus_rst);
  assign cap_overrun = ovr_q;
  assign par_in_err  = perr_q;

  word_fifo #(.WIDTH(CAP_W), .DEPTH(DEPTH)) u_fifo (
    .clock     (clock),
    .clr       (rst || bus_rst),
    .in_valid  (cap_push),
    .in_ready  (fifo_in_ready),
    .in_data   (cap_in),
    .out_valid (cap_valid),
    .out_ready (cap_ready),
    .out_data  (cap_data)
  );

  // lane mask from active-low enables
  always_comb begin
    for (int i = 0; i < CBE_W; i++) begin
      cap_lane_mask[i*LANE_W +: LANE_W] =
        {LANE_W{!cap_data.word.cbe_n[i] && !cap_data.addr_phase}};
    end
  end

  property p_par_delay;
    @(posedge clock) disable iff (rst || bus_rst)
      oe_q |=> (par_q == $past(^{out_q.ad, out_q.cbe_n}));
  endproperty
  a_par_delay: assert property (p_par_delay) else $error("parity wrong");

  property p_par_oe;
    @(posedge clock) disable iff (rst || bus_rst)
      oe_q |=> !par_oe_n;
  endproperty
  a_par_oe: assert property (p_par_oe) else $error("parity not driven");

  property p_rel;
    @(posedge clock) disable iff (rst) bus_rst |-> ad_oe_n && par_oe_n;
  endproperty
  a_rel: assert property (p_rel) else $error("driving in reset");

  property p_clr;
    @(posedge clock) disable iff (rst) bus_rst |=> ph_q == ST_IDLE && !ovr_q;
  endproperty
  a_clr: assert property (p_clr) else $error("state kept in reset");

  property p_hold;
    @(posedge clock) disable iff (rst)
      (hold2_q && !brst2_q)
        |=> oe_q == $past(src_en) && (!$past(ovr_q) || ovr_q);
  endproperty
  a_hold: assert property (p_hold) else $error("hold ignored");

  sequence s_start;
    prev_frame_q && !frame_n && ph_q == ST_IDLE;
  endsequence
  sequence s_addr_taken;
    cap_push && cap_in.addr_phase;
  endsequence
  property p_addr;
    @(posedge clock) disable iff (rst || bus_rst)
      s_start |-> s_addr_taken ##1 ph_q == ST_DATA;
  endproperty
  a_addr: assert property (p_addr) else $error("phase order");

  property p_wait;
    @(posedge clock) disable iff (rst || bus_rst)
      (ph_q == ST_DATA && (irdy_n || trdy_n)) |-> !cap_push;
  endproperty
  a_wait: assert property (p_wait) else $error("wait lost");

  property p_lane;
    @(posedge clock) disable iff (rst)
      (cap_valid && !cap_data.addr_phase && cap_data.word.cbe_n[0])
        |-> cap_lane_mask[LANE_W-1:0] == '0;
  endproperty
  a_lane: assert property (p_lane) else $error("lane mask");
endmodule // host_port
`default_nettype wire

// ---- host_port_pkg.sv ----
`default_nettype none
package host_port_pkg;
  localparam int AD_W    = 32;
  localparam int CBE_W   = 4;
  localparam int LANE_W  = 8;
  localparam int FIFO_DEPTH = 32;
  localparam logic [CBE_W-1:0] CBE_IDLE = 4'hF;
  localparam logic [AD_W-1:0]  AD_ZERO  = 32'h0000_0000;

  typedef struct packed {
    logic [AD_W-1:0]  ad;
    logic [CBE_W-1:0] cbe_n;
  } bus_word_s;

  localparam int WORD_W = AD_W + CBE_W;

  typedef struct packed {
    logic       addr_phase;
    bus_word_s  word;
  } captured_s;

  localparam int CAP_W = WORD_W + 1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10
  } phase_e;
endpackage
`default_nettype wire

// ---- host_agent.sv ----
`default_nettype none
module host_agent (
  input  wire logic        clock,
  output logic             frame_n,
  output logic             irdy_n,
  output logic             trdy_n,
  output logic      [31:0] ad,
  output logic      [3:0]  cbe_n,
  output logic             par
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip;
  initial begin
    flip = 1'b0;
    {frame_n, irdy_n, trdy_n} = 3'h7;
    {ad, cbe_n} = 36'h0;
    par = 1'b0;
  end
  // one bus cycle, changed at the falling edge
  task automatic phase(input logic f, i, t, input logic [35:0] w);
    @(negedge clock);
    par = ^{ad, cbe_n} ^ flip;
    {frame_n, irdy_n, trdy_n} = {f, i, t};
    {ad, cbe_n} = w;
  endtask
  // corrupts the parity driven from now on
  task automatic set_flip(input logic v);
    flip = v;
  endtask
  // address phase then n data phases, optional target waits
  task automatic xfer(input int n, input bit slow, ref logic [36:0] q[$]);
    logic [35:0] w;
    logic        t;
    w = {$urandom, 4'($urandom)};
    phase(1'b0, 1'b1, 1'b1, w);
    q.push_back({1'b1, w});
    for (int k = 0; k < n; k++) begin
      w = {$urandom, 4'($urandom)};
      do begin
        t = slow && $urandom_range(1);
        phase(k == n - 1, 1'b0, t, w);
      end while (t);
      q.push_back({1'b0, w});
    end
    phase(1'b1, 1'b1, 1'b1, ~w);
    phase(1'b1, 1'b1, 1'b1, w);
  endtask
endmodule // host_agent
`default_nettype wire

// ---- host_port_tb.sv ----
`default_nettype none
module host_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import host_port_pkg::*;
  `define CHK(a, b) chk(64'(a), 64'(b))
  logic        clock, rst, bus_reset_n_in, hold_mode, src_en, cap_ready;
  logic        stall, frame_n, irdy_n, trdy_n, par, par_out, par_oe_n;
  logic        ad_oe_n, cbe_oe_n, cap_valid, cap_overrun, par_in_err;
  logic [31:0] ad, ad_out, cap_lane_mask;
  logic [3:0]  cbe_n, cbe_n_out;
  logic [36:0] e;
  logic [36:0] exp_q[$];
  bus_word_s   src_word;
  captured_s   cap_data;
  int          n_errors, compares, n_perr;
  host_port dut (
    .clock, .rst, .bus_reset_n_in, .hold_mode,
    .frame_n_in(frame_n), .irdy_n_in(irdy_n), .trdy_n_in(trdy_n),
    .ad_in(ad), .ad_out, .ad_oe_n, .cbe_n_in(cbe_n), .cbe_n_out, .cbe_oe_n,
    .par_in(par), .par_out, .par_oe_n, .src_en, .src_word, .cap_data,
    .cap_valid, .cap_ready, .cap_overrun, .cap_lane_mask, .par_in_err
  );
  host_agent agent (.clock, .frame_n, .irdy_n, .trdy_n, .ad, .cbe_n, .par);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  function automatic void chk(logic [63:0] a, logic [63:0] b);
    compares++;
    if (a !== b) begin
      n_errors++;
      $display("unexpected at %0t: %h vs %h", $time, a, b);
    end
  endfunction
  function automatic logic [31:0] mask(logic [36:0] w);
    for (int i = 0; i < 4; i++) mask[8*i+:8] = {8{!w[36] && !w[i]}};
  endfunction
  task automatic test_done();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(negedge clock) cap_ready <= !stall && $urandom_range(1);
  always @(posedge clock) if (par_in_err === 1'b1) n_perr++;
  always @(posedge clock) begin
    if (cap_valid === 1'b1 && cap_ready === 1'b1) begin
      e = exp_q.pop_front();
      `CHK(cap_data, e);
      `CHK(cap_lane_mask, mask(e));
    end
  end
  // streams n words out, checks drive and late parity
  task automatic drive(input int n);
    logic [35:0] w[$];
    for (int i = 0; i < n + 2; i++) begin
      @(negedge clock);
      if (i > 0 && i <= n)
        `CHK({ad_oe_n, cbe_oe_n, ad_out, cbe_n_out}, {2'b00, w[i-1]});
      if (i > 1)
        `CHK({par_oe_n, par_out}, {1'b0, ^w[i-2]});
      src_en = i < n;
      src_word = {$urandom, 4'($urandom)};
      w.push_back(src_word);
    end
  endtask
  task automatic bus_rst(input logic hold, input logic kept);
    hold_mode = hold;
    bus_reset_n_in = 1'b0;
    src_en = 1'b1;
    repeat (4) @(negedge clock);
    if (!hold) agent.xfer(1, 0, exp_q);
    if (!hold) exp_q.delete();
    `CHK({ad_oe_n, cbe_oe_n, par_oe_n}, {3{!hold}});
    `CHK({cap_overrun, cap_valid}, {kept, kept});
    bus_reset_n_in = 1'b1;
    src_en = 1'b0;
    hold_mode = 1'b0;
    repeat (3) @(negedge clock);
  endtask
  initial begin
    {rst, bus_reset_n_in, hold_mode, src_en, stall} = 5'b11000;
    src_word = '0;
    n_errors = 0;
    compares = 0;
    n_perr = 0;
    void'($urandom(32'h9691));
    repeat (5) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    drive(1);
    drive(6);
    for (int s = 0; s < 3; s++) agent.xfer(1 + s * 2, s > 0, exp_q);
    repeat (30) @(negedge clock);
    `CHK(exp_q.size(), 0);
    `CHK(n_perr, 0);
    stall = 1'b1;
    agent.xfer(34, 0, exp_q);
    repeat (6) @(negedge clock);
    `CHK(cap_overrun, 1'b1);
    while (exp_q.size() > FIFO_DEPTH) void'(exp_q.pop_back());
    bus_rst(1'b1, 1'b1);
    stall = 1'b0;
    repeat (150) @(negedge clock);
    `CHK(exp_q.size(), 0);
    bus_rst(1'b0, 1'b0);
    drive(2);
    agent.set_flip(1'b1);
    agent.xfer(2, 1, exp_q);
    agent.set_flip(1'b0);
    repeat (30) @(negedge clock);
    `CHK(exp_q.size(), 0);
    `CHK(n_perr > 0, 1'b1);
    test_done();
  end
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
endmodule // host_port_tb
`default_nettype wire
